// [include/ppc_pkg.sv]
// constants and register map of the preset pulse counter
package ppc_pkg;
    // ==========================================
    // clock and time base
    localparam int unsigned PPC_CLK_HZ      = 200_000_000;
    localparam int unsigned PPC_SEC_UNIT    = 1;
    localparam int unsigned PPC_SEC_CYCLES  = PPC_CLK_HZ * PPC_SEC_UNIT;
    // ==========================================
    // register byte offsets
    localparam logic [5:0]  PPC_OFF_CTRL    = 6'h00;
    localparam logic [5:0]  PPC_OFF_PRESET  = 6'h04;
    localparam logic [5:0]  PPC_OFF_LIMIT0  = 6'h08;
    localparam logic [5:0]  PPC_OFF_LIMIT1  = 6'h0c;
    localparam logic [5:0]  PPC_OFF_DELAY   = 6'h10;
    localparam logic [5:0]  PPC_OFF_SCALER  = 6'h14;
    localparam logic [5:0]  PPC_OFF_DIVIDE  = 6'h18;
    localparam logic [5:0]  PPC_OFF_COUNT   = 6'h1c;
    localparam logic [5:0]  PPC_OFF_TOTAL   = 6'h20;
    localparam logic [5:0]  PPC_OFF_BATCH   = 6'h24;
    localparam logic [5:0]  PPC_OFF_TIME    = 6'h28;
    localparam logic [5:0]  PPC_OFF_STATUS  = 6'h2c;
    // ==========================================
    // control and status fields
    localparam int unsigned PPC_CTRL_MODE_LSB  = 0;
    localparam int unsigned PPC_CTRL_SYS_LSB   = 3;
    localparam int unsigned PPC_CTRL_LATCH_LSB = 5;
    localparam int unsigned PPC_CTRL_SHOWB_BIT = 7;
    localparam int unsigned PPC_STAT_OVR_BIT   = 2;
    // ==========================================
    // reset values and ranges
    localparam logic [31:0] PPC_PRESET_RST  = 32'h0000_03e8;
    localparam logic [31:0] PPC_LIMIT_RST   = 32'h0000_0000;
    localparam logic [23:0] PPC_DELAY_MIN   = 24'h00_0001;
    localparam logic [23:0] PPC_DELAY_MAX   = 24'h98_967f;
    localparam logic [23:0] PPC_SCALER_MAX  = 24'h98_967f;
    localparam logic [23:0] PPC_SCALE_ONE   = 24'h01_86a0;
    localparam logic [31:0] PPC_DISP_MAX    = 32'h0098_967f;
    localparam logic [9:0]  PPC_HOUR_MAX    = 10'h3e7;
    localparam logic [5:0]  PPC_MINSEC_MAX  = 6'h3b;
    // ==========================================
    // modes
    typedef enum logic [2:0] {
        PPC_UP_MANUAL, PPC_UP_AUTO, PPC_UP_DELAY,
        PPC_DN_MANUAL, PPC_DN_AUTO, PPC_DN_DELAY
    } ppc_mode_t;
    typedef enum logic [1:0] {
        PPC_SYS_COUNTER, PPC_SYS_RATE, PPC_SYS_RPM, PPC_SYS_FREQ
    } ppc_sys_t;
endpackage

// [rtl/ppc_counter.sv]
// preset pulse counter channel with totalizer, batch, scaling, run time and avalon registers
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
module ppc_counter
    import ppc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = PPC_SEC_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        pulse_in,
    input  wire logic        channel_choose_key_in,
    input  wire logic        reset_key_in,
    input  wire logic        data_key_in,
    input  wire logic        time_key_in,
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [1:0]  limit_out,
    output logic      [31:0] count_out,
    output logic             over_range_out
);
    // refused at elaboration: a second shorter than two cycles leaves the divider nothing to count
    if (SEC_CYCLES < 2) begin
        $error("SEC_CYCLES too small");
    end
    // ==========================================
    // register bus
    logic        ack_q;
    logic        wr_en;
    logic [31:0] ctrl_q, preset_q, lim0_q, lim1_q, divide_q, rdata_d;
    logic [23:0] delay_q, scaler_q;
    logic [31:0] count_q, total_q, batch_q;
    logic [9:0]  hour_q;
    logic [5:0]  min_q, sec_q;
    logic        delay_act_q, ovr_q;
    logic [1:0]  lim_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // one wait cycle per access; the write lands on the edge waitrequest is low
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign wr_en = avs_write_in & ack_q;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) ack_q <= 1'b0;
        else ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address_in)
            PPC_OFF_CTRL:   rdata_d = ctrl_q;
            PPC_OFF_PRESET: rdata_d = preset_q;
            PPC_OFF_LIMIT0: rdata_d = lim0_q;
            PPC_OFF_LIMIT1: rdata_d = lim1_q;
            PPC_OFF_DELAY:  rdata_d = {8'h00, delay_q};
            PPC_OFF_SCALER: rdata_d = {8'h00, scaler_q};
            PPC_OFF_DIVIDE: rdata_d = divide_q;
            PPC_OFF_COUNT:  rdata_d = count_q;
            PPC_OFF_TOTAL:  rdata_d = total_q;
            PPC_OFF_BATCH:  rdata_d = batch_q;
            PPC_OFF_TIME:   rdata_d = {10'h000, hour_q, min_q, sec_q};
            PPC_OFF_STATUS: rdata_d = {28'h000_0000, delay_act_q, ovr_q, lim_q};
            default:        rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) avs_readdata_out <= 32'h0000_0000;
        else if (avs_read_in & ~ack_q) avs_readdata_out <= rdata_d;
    end

    logic [31:0] delay_w, scaler_w;
    assign delay_w  = merge({8'h00, delay_q}, avs_writedata_in, avs_byteenable_in);
    assign scaler_w = merge({8'h00, scaler_q}, avs_writedata_in, avs_byteenable_in);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q   <= 32'h0000_0000;
            preset_q <= PPC_PRESET_RST;
            lim0_q   <= PPC_LIMIT_RST;
            lim1_q   <= PPC_LIMIT_RST;
            delay_q  <= PPC_DELAY_MIN;
            scaler_q <= 24'h00_0000;
            divide_q <= 32'h0000_0001;
        end else if (wr_en) begin
            case (avs_address_in)
                PPC_OFF_CTRL:   ctrl_q   <= merge(ctrl_q, avs_writedata_in, avs_byteenable_in) & 32'h0000_00ff;
                PPC_OFF_PRESET: preset_q <= merge(preset_q, avs_writedata_in, avs_byteenable_in);
                PPC_OFF_LIMIT0: lim0_q   <= merge(lim0_q, avs_writedata_in, avs_byteenable_in);
                PPC_OFF_LIMIT1: lim1_q   <= merge(lim1_q, avs_writedata_in, avs_byteenable_in);
                PPC_OFF_DELAY:  delay_q  <= (delay_w[23:0] < PPC_DELAY_MIN) ? PPC_DELAY_MIN :
                                            (delay_w[31:24] != 8'h00 || delay_w[23:0] > PPC_DELAY_MAX) ?
                                            PPC_DELAY_MAX : delay_w[23:0];
                PPC_OFF_SCALER: scaler_q <= (scaler_w[31:24] != 8'h00 || scaler_w[23:0] > PPC_SCALER_MAX) ?
                                            PPC_SCALER_MAX : scaler_w[23:0];
                PPC_OFF_DIVIDE: divide_q <= merge(divide_q, avs_writedata_in, avs_byteenable_in);
                default: ;
            endcase
        end
    end

    ppc_mode_t mode;
    ppc_sys_t  sys;
    logic      is_down, show_batch;
    logic [1:0] latch;
    assign mode       = ppc_mode_t'(ctrl_q[PPC_CTRL_MODE_LSB +: 3]);
    assign sys        = ppc_sys_t'(ctrl_q[PPC_CTRL_SYS_LSB +: 2]);
    assign latch      = ctrl_q[PPC_CTRL_LATCH_LSB +: 2];
    assign show_batch = ctrl_q[PPC_CTRL_SHOWB_BIT];
    assign is_down    = (mode == PPC_DN_MANUAL) || (mode == PPC_DN_AUTO) || (mode == PPC_DN_DELAY);

    // ==========================================
    // keys, pulse edge and second tick
    logic pulse_q, cnt_key_q, bat_key_q, tim_key_q;
    logic cnt_key, bat_key, tim_key, pulse_ev, cnt_clr, bat_clr, tim_clr;
    logic [31:0] tick_cnt_q;
    logic sec_tick;
    assign cnt_key  = channel_choose_key_in & reset_key_in;
    assign bat_key  = data_key_in & reset_key_in & show_batch;
    assign tim_key  = time_key_in & reset_key_in;
    assign pulse_ev = pulse_in & ~pulse_q;
    assign cnt_clr  = cnt_key & ~cnt_key_q;
    assign bat_clr  = bat_key & ~bat_key_q;
    assign tim_clr  = tim_key & ~tim_key_q;
    assign sec_tick = (tick_cnt_q == SEC_CYCLES - 1);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {pulse_q, cnt_key_q, bat_key_q, tim_key_q} <= 4'h0;
        end else begin
            {pulse_q, cnt_key_q, bat_key_q, tim_key_q} <= {pulse_in, cnt_key, bat_key, tim_key};
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) tick_cnt_q <= 32'h0000_0000;
        else if (sec_tick | tim_clr) tick_cnt_q <= 32'h0000_0000;
        else tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end

    // ==========================================
    // scaling and division
    logic [23:0] acc_q, acc_sum;
    logic [31:0] div_cnt_q;
    logic [7:0]  step;
    logic        use_scaler, use_div;
    assign use_scaler = (scaler_q != 24'h00_0000);
    assign use_div    = ~use_scaler && (divide_q > 32'h0000_0001);
    assign acc_sum    = acc_q + scaler_q;

    always_comb begin
        step = 8'h01;
        if (use_scaler) begin
            step = 8'(acc_sum / PPC_SCALE_ONE);
        end else if (use_div) begin
            step = (div_cnt_q == divide_q - 32'h0000_0001) ? 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_q     <= 24'h00_0000;
            div_cnt_q <= 32'h0000_0000;
        end else if (pulse_ev) begin
            // divider idles while scaler is set
            acc_q     <= use_scaler ? 24'(acc_sum - 24'(step) * PPC_SCALE_ONE) : 24'h00_0000;
            div_cnt_q <= (~use_div || step != 8'h00) ? 32'h0000_0000 : div_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================
    // channel count
    logic        counting, delay_done, cycle_hit, moved_q;
    logic [32:0] up_sum;
    logic [23:0] delay_left_q;
    assign counting   = pulse_ev && (sys != PPC_SYS_FREQ) && (step != 8'h00);
    assign up_sum     = {1'b0, count_q} + {25'h000_0000, step};
    assign delay_done = delay_act_q && sec_tick && (delay_left_q == PPC_DELAY_MIN);
    always_comb begin
        // a cycle ends at preset going up or zero going down
        cycle_hit = 1'b0;
        if (counting) begin
            if (is_down) cycle_hit = (count_q != 32'h0000_0000) && ({24'h00_0000, step} >= count_q);
            else cycle_hit = (count_q < preset_q) && (up_sum >= {1'b0, preset_q});
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= 32'h0000_0000;
            moved_q <= 1'b0;
        end else begin
            moved_q <= 1'b0;
            if (cnt_clr) begin
                count_q <= is_down ? preset_q : 32'h0000_0000;
            end else if (delay_done) begin
                count_q <= (mode == PPC_DN_DELAY) ? preset_q : 32'h0000_0000;
            end else if (counting && !is_down) begin
                moved_q <= 1'b1;
                // auto return to zero at preset
                if (mode == PPC_UP_AUTO && cycle_hit) count_q <= 32'h0000_0000;
                else if (up_sum > {1'b0, PPC_DISP_MAX}) count_q <= PPC_DISP_MAX;
                else count_q <= up_sum[31:0];
            end else if (counting && count_q != 32'h0000_0000) begin
                moved_q <= 1'b1;
                if (mode == PPC_DN_AUTO && cycle_hit) count_q <= preset_q;
                else if (cycle_hit) count_q <= 32'h0000_0000;
                else count_q <= count_q - {24'h00_0000, step};
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            delay_act_q  <= 1'b0;
            delay_left_q <= PPC_DELAY_MIN;
        end else if (cnt_clr || delay_done) begin
            delay_act_q  <= 1'b0;
        end else if (!delay_act_q && cycle_hit && (mode == PPC_UP_DELAY || mode == PPC_DN_DELAY)) begin
            delay_act_q  <= 1'b1;
            delay_left_q <= delay_q;
        end else if (delay_act_q && sec_tick) begin
            delay_left_q <= delay_left_q - PPC_DELAY_MIN;
        end
    end

    // over-range is sticky; a pulse landing on a clear still sets it
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) ovr_q <= 1'b0;
        else if (counting && !is_down && !cycle_hit && up_sum > {1'b0, PPC_DISP_MAX}) ovr_q <= 1'b1;
        else if (wr_en && avs_address_in == PPC_OFF_STATUS && avs_writedata_in[PPC_STAT_OVR_BIT]) ovr_q <= 1'b0;
    end

    // ==========================================
    // limit outputs
    logic [1:0] lim_reach;
    assign lim_reach[0] = is_down ? (count_q <= lim0_q) : (count_q >= lim0_q);
    assign lim_reach[1] = is_down ? (count_q <= lim1_q) : (count_q >= lim1_q);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) lim_q <= 2'b00;
        else if (cnt_clr) lim_q <= 2'b00;
        else if (delay_done) lim_q <= lim_q & latch;
        // energize once the count reaches a limit
        else if (moved_q) lim_q <= lim_q | lim_reach;
    end
    assign limit_out      = lim_q;
    assign count_out      = count_q;
    assign over_range_out = ovr_q;

    // ==========================================
    // totalizer, batch, run time
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) total_q <= 32'h0000_0000;
        // every step accumulates outside frequency mode
        else if (counting) total_q <= total_q + {24'h00_0000, step};
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) batch_q <= 32'h0000_0000;
        // completed cycle, kept over a clear in the same cycle
        else if (cycle_hit) batch_q <= batch_q + 32'h0000_0001;
        else if (bat_clr) batch_q <= 32'h0000_0000;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {hour_q, min_q, sec_q} <= 22'h00_0000;
        end else if (tim_clr) begin
            {hour_q, min_q, sec_q} <= 22'h00_0000;
        end else if (sec_tick && !(hour_q == PPC_HOUR_MAX && min_q == PPC_MINSEC_MAX && sec_q == PPC_MINSEC_MAX)) begin
            // hours minutes seconds, stops at the top
            sec_q <= (sec_q == PPC_MINSEC_MAX) ? 6'h00 : sec_q + 6'h01;
            if (sec_q == PPC_MINSEC_MAX) begin
                min_q <= (min_q == PPC_MINSEC_MAX) ? 6'h00 : min_q + 6'h01;
                if (min_q == PPC_MINSEC_MAX) hour_q <= hour_q + 10'h001;
            end
        end
    end

    // ==========================================
    // checks
    mode_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        cnt_clr |=> count_q == (is_down ? preset_q : 32'h0000_0000))
        else $error("manual clear value wrong");
    limit_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        cnt_clr |=> limit_out == 2'b00)
        else $error("limits not dropped on clear");
    auto_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (mode == PPC_UP_AUTO && cycle_hit && !cnt_clr && !delay_done) |=> count_q == 32'h0000_0000)
        else $error("mode 1 did not return to zero");
    down_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (mode == PPC_DN_MANUAL && count_q == 32'h0000_0000 && !cnt_clr) |=> count_q == 32'h0000_0000)
        else $error("mode 3 left zero without reload");
    auto_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (mode == PPC_DN_AUTO && cycle_hit && !cnt_clr && !delay_done) |=> count_q == $past(preset_q))
        else $error("mode 4 did not reload");
    delay_end_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (delay_done && !cnt_clr && mode == PPC_DN_DELAY) |=> count_q == $past(preset_q) && !(|(limit_out & ~latch)))
        else $error("delay end did not reload and release");
    total_step_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sys == PPC_SYS_FREQ) |=> $stable(total_q) && ($stable(batch_q) || $past(bat_clr)))
        else $error("total or batch moved in frequency mode");
    batch_clr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (bat_clr && !cycle_hit) |=> batch_q == 32'h0000_0000)
        else $error("batch not cleared");
    time_clr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        tim_clr |=> {hour_q, min_q, sec_q} == 22'h00_0000 ##1 tick_cnt_q == 32'h0000_0001)
        else $error("run time not restarted");
    range_cap_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !is_down |-> count_q <= PPC_DISP_MAX || $past(cnt_clr) || $past(delay_done) || $past(count_q) > PPC_DISP_MAX)
        else $error("count passed display range");
    bus_wait_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("bus answer not after one wait cycle");
endmodule

// [test/ppc_panel_model.sv]
// front-panel keypad and pulse sensor model for the counter channel
`timescale 1ns/10ps
module ppc_panel_model (
    input  wire logic sys_clk_in,
    output logic      pulse_out,
    output logic      channel_choose_key_out,
    output logic      reset_key_out,
    output logic      data_key_out,
    output logic      time_key_out
);
    // ==========================================
    // idle panel
    initial begin
        pulse_out = 1'b0;
        {channel_choose_key_out, reset_key_out, data_key_out, time_key_out} = 4'h0;
    end
    // ==========================================
    // sensor pulses, a low sample between each so every edge counts once
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge sys_clk_in);
            pulse_out <= 1'b1;
            @(posedge sys_clk_in);
            pulse_out <= 1'b0;
        end
        repeat (3) @(posedge sys_clk_in);
    endtask
    // ==========================================
    // key combination held two cycles, then every key released
    task automatic keys(input logic ch, input logic rs, input logic dt, input logic tm);
        @(posedge sys_clk_in);
        {channel_choose_key_out, reset_key_out, data_key_out, time_key_out} <= {ch, rs, dt, tm};
        repeat (2) @(posedge sys_clk_in);
        {channel_choose_key_out, reset_key_out, data_key_out, time_key_out} <= 4'h0;
        repeat (2) @(posedge sys_clk_in);
    endtask
endmodule

// [test/tb_top.sv]
// self-checking testbench for the preset pulse counter channel
`timescale 1ns/10ps
module tb_top
    import ppc_pkg::*;
;
    logic        sys_clk_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        pulse, ch_key, rs_key, dt_key, tm_key;
    logic [5:0]  avs_address   = 6'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, count_out;
    logic        avs_waitrequest, over_range;
    logic [1:0]  limit_out;
    int          miscompares = 0;
    int          tests_run   = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    ppc_panel_model pm (.sys_clk_in(sys_clk_in), .pulse_out(pulse), .channel_choose_key_out(ch_key),
        .reset_key_out(rs_key), .data_key_out(dt_key), .time_key_out(tm_key));
    ppc_counter #(.SEC_CYCLES(20)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pulse_in(pulse),
        .channel_choose_key_in(ch_key), .reset_key_in(rs_key), .data_key_in(dt_key), .time_key_in(tm_key),
        .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest), .limit_out(limit_out), .count_out(count_out),
        .over_range_out(over_range));
    // ==========================================
    // shared checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // holds the request until waitrequest is sampled low, data taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge sys_clk_in);
        // no cycle count assumed; only the watchdog ends a hung wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk_in);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask
    task automatic outs(input logic [31:0] c, input logic [1:0] l);
        chk("count", count_out, c);
        chk("limits", {30'h0, limit_out}, {30'h0, l});
        chk("over range", {31'h0, over_range}, 32'h0);
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs();
        rd_chk("preset", PPC_OFF_PRESET, PPC_PRESET_RST);
        rd_chk("delay", PPC_OFF_DELAY, 32'h1);
        // only the low byte lane is written
        avs_byteenable <= 4'h1;
        wr(PPC_OFF_PRESET, 32'hffff_ff07);
        avs_byteenable <= 4'hf;
        rd_chk("preset lane", PPC_OFF_PRESET, 32'h307);
        wr(PPC_OFF_DELAY, 32'h0);
        rd_chk("delay min", PPC_OFF_DELAY, 32'h1);
        wr(PPC_OFF_DELAY, 32'hffff_ffff);
        rd_chk("delay max", PPC_OFF_DELAY, 32'h98_967f);
        wr(PPC_OFF_SCALER, 32'hffff_ffff);
        rd_chk("scaler max", PPC_OFF_SCALER, 32'h98_967f);
        wr(PPC_OFF_SCALER, 32'h0);
        wr(6'h30, 32'h5);
        rd_chk("unmapped", 6'h30, 32'h0);
        outs(32'h0, 2'b00);
    endtask
    task automatic t_up_manual();
        wr(PPC_OFF_LIMIT0, 32'h3);
        wr(PPC_OFF_LIMIT1, 32'h64);
        pm.keys(1, 1, 0, 0);
        pm.pulses(3);
        outs(32'h3, 2'b01);
        wr(PPC_OFF_COUNT, 32'h9);
        rd_chk("count ro", PPC_OFF_COUNT, 32'h3);
        pm.keys(1, 1, 0, 0);
        outs(32'h0, 2'b00);
    endtask
    task automatic t_up_auto();
        wr(PPC_OFF_PRESET, 32'h4);
        wr(PPC_OFF_CTRL, 32'h81);
        pm.pulses(5);
        chk("count", count_out, 32'h1);
        rd_chk("batch", PPC_OFF_BATCH, 32'h1);
        rd_chk("total", PPC_OFF_TOTAL, 32'h8);
        pm.keys(0, 1, 1, 0);
        rd_chk("batch clr", PPC_OFF_BATCH, 32'h0);
    endtask
    task automatic t_down();
        wr(PPC_OFF_PRESET, 32'h2);
        wr(PPC_OFF_LIMIT1, 32'h1);
        wr(PPC_OFF_CTRL, 32'h3);
        pm.keys(1, 1, 0, 0);
        outs(32'h2, 2'b00);
        pm.pulses(4);
        outs(32'h0, 2'b11);
        pm.keys(1, 1, 0, 0);
        outs(32'h2, 2'b00);
        wr(PPC_OFF_CTRL, 32'h4);
        // the pulse that reaches zero reloads at once
        pm.pulses(2);
        chk("count", count_out, 32'h2);
        pm.pulses(1);
        chk("count", count_out, 32'h1);
        rd_chk("batch down", PPC_OFF_BATCH, 32'h2);
    endtask
    task automatic t_delay();
        wr(PPC_OFF_DELAY, 32'h2);
        wr(PPC_OFF_LIMIT0, 32'h1);
        // mode 2 with limit 0 latched
        wr(PPC_OFF_CTRL, 32'h22);
        pm.keys(1, 1, 0, 0);
        // no pulses arrive inside the two second delay
        pm.pulses(2);
        outs(32'h2, 2'b11);
        repeat (45) @(posedge sys_clk_in);
        outs(32'h0, 2'b01);
        wr(PPC_OFF_CTRL, 32'h5);
        pm.keys(1, 1, 0, 0);
        pm.pulses(2);
        outs(32'h0, 2'b11);
        repeat (45) @(posedge sys_clk_in);
        outs(32'h2, 2'b00);
    endtask
    task automatic t_scale_time();
        wr(PPC_OFF_CTRL, 32'h0);
        wr(PPC_OFF_SCALER, 32'h30d40);
        wr(PPC_OFF_DIVIDE, 32'h2);
        pm.keys(1, 1, 0, 0);
        pm.pulses(3);
        chk("scaled", count_out, 32'h6);
        wr(PPC_OFF_SCALER, 32'h0);
        pm.keys(1, 1, 0, 0);
        pm.pulses(4);
        chk("divided", count_out, 32'h2);
        wr(PPC_OFF_CTRL, 32'h18);
        pm.pulses(2);
        chk("freq hold", count_out, 32'h2);
        wr(PPC_OFF_CTRL, 32'h8);
        pm.pulses(2);
        chk("rate count", count_out, 32'h3);
        pm.keys(0, 0, 0, 1);
        pm.keys(0, 1, 0, 1);
        rd_chk("time clr", PPC_OFF_TIME, 32'h0);
        repeat (20) @(posedge sys_clk_in);
        rd_chk("time sec", PPC_OFF_TIME, 32'h1);
    endtask
    // ==========================================
    // run and verdict
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_up_manual();
        t_up_auto();
        t_down();
        t_delay();
        t_scale_time();
        tally_and_finish();
    end
    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        miscompares++;
        tally_and_finish();
    end
endmodule
